// [src/serial_write_defs.vh]
`ifndef SERIAL_WRITE_DEFS_VH
`define SERIAL_WRITE_DEFS_VH

// Frame lengths of the two variants
`define WORD_BITS_NARROW 16
`define WORD_BITS_WIDE 24
// Default variant
`define WORD_BITS_DEFAULT 24
// Bit counter width, enough for 24
`define CNT_W 5
// Reset values
`define CNT_RST 5'h00
`define LINK_IDLE_RST 1'b1
// Pin synchroniser: frame select, serial clock, serial data
`define SYNC_W 3
`define SYNC_RST 3'h7
`define PIN_FRAME 2
`define PIN_SCLK 1
`define PIN_SDATA 0

`endif

// [src/link_sync.v]
`timescale 1ns/10ps
`include "serial_write_defs.vh"

module link_sync #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;

endmodule

// [src/dac_serial_write_input.v]
`timescale 1ns/10ps
`include "serial_write_defs.vh"

module dac_serial_write_input #(
	parameter WORD_BITS = `WORD_BITS_DEFAULT
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire frame_n_i,
	input wire sclk_i,
	input wire sdata_i,
	output wire [WORD_BITS-1:0] cmd_word_o,
	output wire cmd_valid_o,
	output wire frame_active_o,
	output wire frame_abort_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Pins are asynchronous to clk_i; two stages before any logic reads them
	wire [`SYNC_W-1:0] pins_sync;

	link_sync #(
		.WIDTH(`SYNC_W),
		.RST_VAL(`SYNC_RST)
	) u_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.async_i({frame_n_i, sclk_i, sdata_i}),
		.sync_o(pins_sync)
	);

	// Data shares the clock's delay, so setup at the pins is kept
	wire frame_n_s = pins_sync[`PIN_FRAME];
	wire sclk_s = pins_sync[`PIN_SCLK];
	wire sdata_s = pins_sync[`PIN_SDATA];

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	// History resets to the idle high level: no false edge after reset
	reg frame_n_d_ff;
	reg sclk_d_ff;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			frame_n_d_ff <= `LINK_IDLE_RST;
			sclk_d_ff <= `LINK_IDLE_RST;
		end else begin
			frame_n_d_ff <= frame_n_s;
			sclk_d_ff <= sclk_s;
		end
	end

	wire frame_fall = frame_n_d_ff & ~frame_n_s;
	// Bits are taken on the serial clock's falling edge
	wire sclk_fall = sclk_d_ff & ~sclk_s;

	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SHIFT = 2'h1;
	localparam [1:0] ST_DONE = 2'h2;

	localparam [31:0] LAST_CNT_FULL = WORD_BITS - 1;
	localparam [`CNT_W-1:0] LAST_CNT = LAST_CNT_FULL[`CNT_W-1:0];

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [`CNT_W-1:0] cnt_ff;
	reg [`CNT_W-1:0] nxt_cnt;

	// Strobes shared by the sections below
	wire in_shift = (state_ff == ST_SHIFT);
	wire take_bit = in_shift & ~frame_n_s & sclk_fall;
	wire last_bit = take_bit & (cnt_ff == LAST_CNT);
	// Frame select high mid-frame wins over a clock fall
	wire cut_frame = in_shift & frame_n_s;

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				// Clock edges outside a frame are ignored
				if (frame_fall) begin
					nxt_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				// A cut frame drops the partial word, no update
				if (cut_frame) begin
					nxt_state = ST_IDLE;
				end else if (last_bit) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				// Extra clocks ignored until frame select goes high
				if (frame_n_s) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// Bit counter
	// ----------------------------------------
	// Sized for the wide variant; the narrow one uses part of it
	always @* begin
		nxt_cnt = cnt_ff;
		if ((state_ff == ST_IDLE) && frame_fall) begin
			// Each frame counts from zero, whatever came before
			nxt_cnt = `CNT_RST;
		end else if (take_bit && !last_bit) begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= `CNT_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// ----------------------------------------
	// Input shift register
	// ----------------------------------------
	// One stage per bit; the first bit in ends at the top
	wire [WORD_BITS-1:0] shift_word;
	wire [WORD_BITS-1:0] nxt_shift = {shift_word[WORD_BITS-2:0], sdata_s};
	genvar gi;

	generate
		for (gi = 0; gi < WORD_BITS; gi = gi + 1) begin : g_bit
			reg bit_ff;
			always @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					bit_ff <= 1'b0;
				end else if (take_bit) begin
					bit_ff <= nxt_shift[gi];
				end
			end
			assign shift_word[gi] = bit_ff;
		end
	endgenerate

	// ----------------------------------------
	// Command word
	// ----------------------------------------
	// Holds the last complete word; a cut frame leaves it alone
	reg [WORD_BITS-1:0] word_ff;
	wire [WORD_BITS-1:0] nxt_word = last_bit ? nxt_shift : word_ff;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_ff <= {WORD_BITS{1'b0}};
		end else begin
			word_ff <= nxt_word;
		end
	end

	// ----------------------------------------
	// Status strobes
	// ----------------------------------------
	// One-cycle pulses; active follows the next state so it is registered too
	reg valid_ff;
	reg abort_ff;
	reg active_ff;
	wire nxt_valid = last_bit;
	wire nxt_abort = cut_frame;
	wire nxt_active = (nxt_state == ST_SHIFT);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			valid_ff <= 1'b0;
			abort_ff <= 1'b0;
		end else begin
			valid_ff <= nxt_valid;
			abort_ff <= nxt_abort;
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			active_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// All outputs come straight from flip-flops
	assign cmd_word_o = word_ff;
	assign cmd_valid_o = valid_ff;
	assign frame_active_o = active_ff;
	assign frame_abort_o = abort_ff;

endmodule

// [dv/swi_props.sv]
`timescale 1ns/10ps
module swi_props #(
	parameter WORD_BITS = 24
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire frame_n_i,
	input wire [WORD_BITS-1:0] cmd_word_o,
	input wire cmd_valid_o,
	input wire frame_active_o,
	input wire frame_abort_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_valid_one_cycle: assert property (cmd_valid_o |=> !cmd_valid_o)
		else $error("valid longer than one cycle");
	a_word_holds: assert property (!cmd_valid_o |-> $stable(cmd_word_o))
		else $error("word changed without valid");
	a_abort_one_cycle: assert property (frame_abort_o |=> !frame_abort_o)
		else $error("abort longer than one cycle");
	a_abort_no_update: assert property (!(frame_abort_o && cmd_valid_o))
		else $error("update on aborted frame");
	a_idle_quiet: assert property (frame_n_i [*5] |-> !frame_active_o)
		else $error("active while frame high");
	a_open_on_low: assert property ($rose(frame_active_o) |-> !$past(frame_n_i, 2))
		else $error("frame opened without select low");
	a_end_reason: assert property ($fell(frame_active_o) |-> cmd_valid_o || frame_abort_o)
		else $error("frame closed without update or abort");
	a_valid_closes: assert property (cmd_valid_o |-> $fell(frame_active_o))
		else $error("update outside the end of a frame");
endmodule
bind dac_serial_write_input swi_props #(.WORD_BITS(WORD_BITS)) chk (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .frame_n_i(frame_n_i), .cmd_word_o(cmd_word_o),
	.cmd_valid_o(cmd_valid_o), .frame_active_o(frame_active_o), .frame_abort_o(frame_abort_o));

// [dv/host_model.sv]
`timescale 1ns/10ps
module host_model (
	input wire clk_i,
	output logic frame_n_o = 1'b1,
	output logic sclk_o = 1'b1,
	output logic sdata_o = 1'b0
);
	task automatic send(input logic [23:0] w, input int n);
		frame_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		for (int i = n - 1; i >= 0; i--) begin
			sdata_o <= w[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
		end
		repeat (4) @(posedge clk_i);
		frame_n_o <= 1'b1;
		sdata_o <= ~sdata_o;
		repeat (8) @(posedge clk_i);
	endtask
	// Clock pulses with frame select high, to be ignored
	task automatic stray(input int n);
		repeat (n) begin
			sclk_o <= 1'b0;
			sdata_o <= ~sdata_o;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
	endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_top;
	localparam WB = 16;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	wire frame_n, sclk, sdata, valid, act, abrt;
	wire [WB-1:0] word;
	int fails = 0, n_checks = 0, seed = 32'hbb89;
	int lens[8] = '{16, 16, 5, 16, 18, 1, 15, 16};
	logic [24:0] q[$];
	logic [23:0] w;
	initial forever #10 clk_i = ~clk_i;
	host_model h (.clk_i(clk_i), .frame_n_o(frame_n), .sclk_o(sclk), .sdata_o(sdata));
	dac_serial_write_input #(.WORD_BITS(WB)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.frame_n_i(frame_n), .sclk_i(sclk), .sdata_i(sdata), .cmd_word_o(word),
		.cmd_valid_o(valid), .frame_active_o(act), .frame_abort_o(abrt));
	always @(posedge clk_i) if (valid || abrt) begin
		`CHK("kind", q[0][24], abrt)
		if (valid) `CHK("word", q[0][WB-1:0], word)
		`CHK("active", 1'b0, act)
		void'(q.pop_front());
	end
	task stop_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		foreach (lens[i]) begin
			w = $random(seed);
			q.push_back(lens[i] < WB ? 25'h1000000 : {1'b0, w >> (lens[i] - WB)});
			h.stray(1 + i % 3);
			h.send(w, lens[i]);
		end
		repeat (20) @(posedge clk_i);
		`CHK("left", 0, q.size())
		stop_test;
	end
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule
